// >>> include/sfrsr_pkg.sv
// Package: constants, states and carriers of the self-refresh save/restore host
package sfrsr_pkg;

    // Software register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
    localparam logic [7:0] REG_CAL_WORDS = 8'h10;

    // Control register field positions
    localparam int CTRL_ENTER_BIT = 0;
    localparam int CTRL_ARM_BIT = 1;
    localparam int CTRL_SRMODE_BIT = 2;

    // Status register field positions
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_GRANT_BIT = 4;
    localparam int STAT_DONE_BIT = 5;
    localparam int STAT_VALID_BIT = 6;
    localparam int STAT_TRAFFIC_BIT = 7;

    // Interrupt event bits
    localparam int EV_SAVED = 0;
    localparam int EV_RESTORED = 1;
    localparam int EV_MISSED = 2;
    localparam int EV_W = 3;

    // Reset values
    localparam logic [2:0] CTRL_RST = 3'h4;
    localparam logic [EV_W-1:0] MASK_RST = 3'h0;

    // Restore strobes must rise within this many controller cycles
    localparam int ARM_WIN_CYC = 50;
    // Registered outputs lag the decision by one edge, so close early
    localparam logic [5:0] ARM_LAST = 6'(ARM_WIN_CYC - 2);

    // Sequencer states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_DRAIN,
        ST_REQ,
        ST_SAVE,
        ST_PARKED,
        ST_INRST,
        ST_ARMWIN,
        ST_RESTORE,
        ST_LOADED,
        ST_NORMAL
    } sfrsr_state_type;

    // Software control fields
    typedef struct packed {
        logic sr_mode;
        logic arm;
        logic enter;
    } sfrsr_ctrl_type;

    // Restore-control strobes toward the memory controller
    typedef struct packed {
        logic bypass;
        logic use_saved;
        logic loaded;
    } sfrsr_rst_type;

endpackage

// >>> design/sfrsr_ctrl.sv
// Host sequencer for DRAM self-refresh entry with calibration save/restore
//
// Overview of operation
// - Memory traffic is gated off before any self-refresh request.
// - Entry starts by raising the sleep request to the controller.
// - After grant, calibration words are copied into local storage.
// - DRAM keeps data through reconfiguration while CKE/RESET_n undisturbed.
// - Bypass and saved-training strobes rise within 50 cycles, held to done.
// - Saved calibration words are written back into the controller.
// - Loaded strobe rises once every word has been written back.
// - Bypass and saved-training strobes drop once training done is seen.
// - Traffic resumes only after the restore sequence completes.
// - Sequencer runs on the memory interface clock.
`timescale 1ns/10ps
`default_nettype none

module sfrsr_ctrl #(
    parameter int CAL_AW = 9,
    parameter int CAL_DW = 32
) (
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    // Software register port
    input wire logic [7:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    output logic IRQ_O,
    // Memory controller handshake
    input wire logic UI_RST_I,
    output logic SLEEP_REQ_O,
    input wire logic SLEEP_GRANT_I,
    output logic BYPASS_BRINGUP_O,
    output logic USE_SAVED_O,
    output logic SAVED_LOADED_O,
    input wire logic TRAINING_DONE_I,
    output logic TRAFFIC_EN_O,
    // Calibration word port of the controller
    output logic [CAL_AW-1:0] CAL_ADDR_O,
    output logic CAL_RD_O,
    input wire logic [CAL_DW-1:0] CAL_RDATA_I,
    output logic CAL_WR_O,
    output logic [CAL_DW-1:0] CAL_WDATA_O
);

    // ========================================================
    // Declarations
    // ========================================================
    localparam logic [CAL_AW:0] WORDS_RST = (CAL_AW+1)'(1 << CAL_AW);

    sfrsr_pkg::sfrsr_state_type st_q;
    sfrsr_pkg::sfrsr_ctrl_type ctrl_q;
    sfrsr_pkg::sfrsr_rst_type rs_q;
    logic [CAL_DW-1:0] mem_q [0:(1<<CAL_AW)-1];
    logic [CAL_AW:0] words_q;
    logic [CAL_AW:0] idx_q;
    logic cap_vld_q;
    logic [CAL_AW-1:0] cap_addr_q;
    logic save_valid_q;
    logic [5:0] win_q;
    logic ui_rst_q;
    logic [sfrsr_pkg::EV_W-1:0] ev_set;
    logic [sfrsr_pkg::EV_W-1:0] irq_stat_q;
    logic [sfrsr_pkg::EV_W-1:0] irq_mask_q;
    logic enter_pulse;
    logic rst_rel;
    logic last_issue;

    // Index compare shared by save and restore loops
    function automatic logic is_last(input logic [CAL_AW:0] i,
                                     input logic [CAL_AW:0] n);
        is_last = (i + 1'b1) >= n;
    endfunction

    assign enter_pulse = WR_I && (ADDR_I == sfrsr_pkg::REG_CTRL)
                         && WDATA_I[sfrsr_pkg::CTRL_ENTER_BIT];
    assign rst_rel = ui_rst_q && !UI_RST_I;
    assign last_issue = is_last(idx_q, words_q);

    // ========================================================
    // Software registers
    // ========================================================
    // Control and word count; enter is a self-clearing request
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ctrl_q <= sfrsr_pkg::CTRL_RST;
            words_q <= WORDS_RST;
            irq_mask_q <= sfrsr_pkg::MASK_RST;
        end else begin
            ctrl_q.enter <= 1'b0;
            if (WR_I && ADDR_I == sfrsr_pkg::REG_CTRL) begin
                ctrl_q <= WDATA_I[2:0];
            end
            if (WR_I && ADDR_I == sfrsr_pkg::REG_IRQ_MASK) begin
                irq_mask_q <= WDATA_I[sfrsr_pkg::EV_W-1:0];
            end
            // Word count is clamped to the local store size
            if (WR_I && ADDR_I == sfrsr_pkg::REG_CAL_WORDS) begin
                words_q <= (WDATA_I[CAL_AW:0] > WORDS_RST) ? WORDS_RST
                           : WDATA_I[CAL_AW:0];
            end
        end
    end

    // Sticky events, write one to clear; a new event beats the clear
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            irq_stat_q <= '0;
        end else begin
            if (WR_I && ADDR_I == sfrsr_pkg::REG_IRQ_STAT) begin
                irq_stat_q <= (irq_stat_q & ~WDATA_I[sfrsr_pkg::EV_W-1:0])
                              | ev_set;
            end else begin
                irq_stat_q <= irq_stat_q | ev_set;
            end
        end
    end

    // Level interrupt from any unmasked sticky bit
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RDATA_O <= '0;
        end else if (RD_I) begin
            case (ADDR_I)
                sfrsr_pkg::REG_CTRL: RDATA_O <= {29'h0, ctrl_q};
                sfrsr_pkg::REG_STATUS: RDATA_O <= {24'h0, TRAFFIC_EN_O,
                    save_valid_q, TRAINING_DONE_I, SLEEP_GRANT_I, st_q};
                sfrsr_pkg::REG_IRQ_STAT: RDATA_O <= {29'h0, irq_stat_q};
                sfrsr_pkg::REG_IRQ_MASK: RDATA_O <= {29'h0, irq_mask_q};
                sfrsr_pkg::REG_CAL_WORDS:
                    RDATA_O <= {{(31-CAL_AW){1'b0}}, words_q};
                default: RDATA_O <= '0;
            endcase
        end else begin
            RDATA_O <= '0;
        end
    end

    // ========================================================
    // Sequencer
    // ========================================================
    // Reset edge of the controller's user interface
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ui_rst_q <= 1'b1;
        end else begin
            ui_rst_q <= UI_RST_I;
        end
    end

    // Main state flow on the interface clock; UI reset overrides all
    // since the far side may be reconfigured under us at any point
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            st_q <= sfrsr_pkg::ST_INRST;
            idx_q <= '0;
            win_q <= '0;
        end else if (UI_RST_I) begin
            st_q <= sfrsr_pkg::ST_INRST;
            idx_q <= '0;
            win_q <= '0;
        end else begin
            case (st_q)
                sfrsr_pkg::ST_INRST: begin
                    if (rst_rel) begin
                        st_q <= sfrsr_pkg::ST_ARMWIN;
                    end
                end
                // Open a window for arming restore
                sfrsr_pkg::ST_ARMWIN: begin
                    win_q <= win_q + 6'h1;
                    idx_q <= '0;
                    if (ctrl_q.arm && save_valid_q) begin
                        st_q <= sfrsr_pkg::ST_RESTORE;
                    end else if (win_q >= sfrsr_pkg::ARM_LAST) begin
                        st_q <= sfrsr_pkg::ST_NORMAL;
                    end
                end
                sfrsr_pkg::ST_RESTORE: begin
                    idx_q <= idx_q + 1'b1;
                    if (last_issue) begin
                        st_q <= sfrsr_pkg::ST_LOADED;
                    end
                end
                sfrsr_pkg::ST_LOADED: begin
                    if (TRAINING_DONE_I) begin
                        st_q <= sfrsr_pkg::ST_IDLE;
                    end
                end
                sfrsr_pkg::ST_NORMAL: begin
                    if (TRAINING_DONE_I) begin
                        st_q <= sfrsr_pkg::ST_IDLE;
                    end
                end
                sfrsr_pkg::ST_IDLE: begin
                    if (enter_pulse) begin
                        st_q <= sfrsr_pkg::ST_DRAIN;
                    end
                end
                // One cycle with traffic already off
                sfrsr_pkg::ST_DRAIN: begin
                    idx_q <= '0;
                    st_q <= ctrl_q.sr_mode ? sfrsr_pkg::ST_REQ
                                           : sfrsr_pkg::ST_SAVE;
                end
                // Wait for the grant before touching data
                sfrsr_pkg::ST_REQ: begin
                    if (SLEEP_GRANT_I) begin
                        st_q <= sfrsr_pkg::ST_SAVE;
                    end
                end
                sfrsr_pkg::ST_SAVE: begin
                    if (!last_issue) begin
                        idx_q <= idx_q + 1'b1;
                    end else if (!cap_vld_q) begin
                        // Pipeline drained only after the last capture
                        idx_q <= idx_q;
                    end
                    if (last_issue && cap_vld_q
                        && cap_addr_q == CAL_AW'(idx_q)) begin
                        st_q <= ctrl_q.sr_mode ? sfrsr_pkg::ST_PARKED
                                               : sfrsr_pkg::ST_IDLE;
                    end
                end
                // Stays parked until the controller is reset again
                sfrsr_pkg::ST_PARKED: begin
                    st_q <= sfrsr_pkg::ST_PARKED;
                end
                default: st_q <= sfrsr_pkg::ST_INRST;
            endcase
        end
    end

    // Events for the interrupt block, one cycle each
    always_comb begin
        ev_set = '0;
        ev_set[sfrsr_pkg::EV_SAVED] = (st_q == sfrsr_pkg::ST_SAVE)
            && last_issue && cap_vld_q && cap_addr_q == CAL_AW'(idx_q)
            && !UI_RST_I;
        ev_set[sfrsr_pkg::EV_RESTORED] = (st_q == sfrsr_pkg::ST_LOADED)
            && TRAINING_DONE_I && !UI_RST_I;
        ev_set[sfrsr_pkg::EV_MISSED] = (st_q == sfrsr_pkg::ST_ARMWIN)
            && !(ctrl_q.arm && save_valid_q)
            && win_q >= sfrsr_pkg::ARM_LAST && ctrl_q.arm && !UI_RST_I;
    end

    // ========================================================
    // Controller-facing outputs
    // ========================================================
    // Sleep request held until the grant
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            SLEEP_REQ_O <= 1'b0;
        end else begin
            SLEEP_REQ_O <= !UI_RST_I && (st_q == sfrsr_pkg::ST_REQ)
                           && !SLEEP_GRANT_I;
        end
    end

    // Traffic only once training is done and idle
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            TRAFFIC_EN_O <= 1'b0;
        end else begin
            TRAFFIC_EN_O <= !UI_RST_I && (st_q == sfrsr_pkg::ST_IDLE)
                            && TRAINING_DONE_I && !enter_pulse;
        end
    end

    // Restore strobes from arming until training done
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rs_q <= '0;
        end else if (UI_RST_I) begin
            rs_q <= '0;
        end else begin
            case (st_q)
                sfrsr_pkg::ST_ARMWIN: begin
                    // Bypass only in the self-refresh flow
                    if (ctrl_q.arm && save_valid_q) begin
                        rs_q.bypass <= ctrl_q.sr_mode;
                        rs_q.use_saved <= 1'b1;
                    end
                end
                sfrsr_pkg::ST_RESTORE: rs_q.loaded <= 1'b0;
                sfrsr_pkg::ST_LOADED: begin
                    if (TRAINING_DONE_I) begin
                        rs_q <= '0;
                    end else begin
                        // Loaded only after the last write has landed
                        rs_q.loaded <= 1'b1;
                    end
                end
                default: rs_q <= '0;
            endcase
        end
    end

    assign BYPASS_BRINGUP_O = rs_q.bypass;
    assign USE_SAVED_O = rs_q.use_saved;
    assign SAVED_LOADED_O = rs_q.loaded;

    // Calibration port: reads while saving, writes while restoring
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            CAL_RD_O <= 1'b0;
            CAL_WR_O <= 1'b0;
            CAL_ADDR_O <= '0;
            CAL_WDATA_O <= '0;
        end else begin
            CAL_RD_O <= !UI_RST_I && (st_q == sfrsr_pkg::ST_SAVE)
                        && (idx_q < words_q) && !(cap_vld_q && last_issue
                        && cap_addr_q == CAL_AW'(idx_q));
            // One word per cycle back into the controller
            CAL_WR_O <= !UI_RST_I && (st_q == sfrsr_pkg::ST_RESTORE);
            CAL_ADDR_O <= CAL_AW'(idx_q);
            CAL_WDATA_O <= mem_q[CAL_AW'(idx_q)];
        end
    end

    // Capture pipeline: read data arrives one cycle after the strobe
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cap_vld_q <= 1'b0;
            cap_addr_q <= '0;
        end else begin
            cap_vld_q <= CAL_RD_O;
            cap_addr_q <= CAL_ADDR_O;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (cap_vld_q) begin
            mem_q[cap_addr_q] <= CAL_RDATA_I;
        end
    end

    // Store holds a full image only after an uninterrupted save
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            save_valid_q <= 1'b0;
        end else if (ev_set[sfrsr_pkg::EV_SAVED]) begin
            save_valid_q <= 1'b1;
        end else if (st_q == sfrsr_pkg::ST_SAVE && !UI_RST_I
                     && idx_q == '0) begin
            save_valid_q <= 1'b0;
        end
    end

endmodule // sfrsr_ctrl

`default_nettype wire

// >>> bench/sfrsr_mc_model.sv
// Behavioural memory controller facing the save/restore sequencer
`timescale 1ns/10ps
`default_nettype none
module sfrsr_mc_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ui_rst_i,
    input wire logic sleep_req_i,
    input wire logic use_saved_i,
    input wire logic bypass_i,
    input wire logic loaded_i,
    input wire logic cal_rd_i,
    input wire logic cal_wr_i,
    input wire logic [2:0] cal_addr_i,
    input wire logic [31:0] cal_wdata_i,
    input wire logic [31:0] seed_i,
    input wire logic [7:0] lat_i,
    output logic grant_o,
    output logic done_o,
    output logic [31:0] cal_rdata_o
);
    logic [31:0] mem [8];
    logic [7:0] t;
    logic in_sr;
    logic cke;
    logic dram_rst_n;
    logic ck_run;

    // ==========================================================
    // DRAM pins
    // parked pin levels
    assign cke = ~in_sr;
    assign dram_rst_n = 1'b1;
    assign ck_run = ~in_sr;

    // ==========================================================
    // Handshake and calibration timing
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            t <= 8'h00;
            grant_o <= 1'b0;
            done_o <= 1'b0;
            in_sr <= 1'b0;
        end else if (ui_rst_i) begin
            t <= 8'h00;
            grant_o <= 1'b0;
            done_o <= 1'b0;
        end else if (sleep_req_i && !grant_o) begin
            t <= t + 8'h01;
            if (t >= lat_i) begin
                grant_o <= 1'b1;
                in_sr <= 1'b1;
            end
        // init only without bypass, then calibrate
        end else if (!done_o && !(use_saved_i && !loaded_i)) begin
            t <= t + 8'h01;
            if (t >= lat_i + (bypass_i ? 8'h00 : 8'h40)) begin
                done_o <= 1'b1;
                in_sr <= 1'b0;
            end
        end else begin
            t <= 8'h00;
        end
    end

    // Calibration store; a new bitstream loses it, idle bus flips
    always_ff @(posedge clk_i) begin
        if (ui_rst_i) begin
            for (int i = 0; i < 8; i++) mem[i] <= seed_i + 32'(i);
        end else if (cal_wr_i) begin
            mem[cal_addr_i] <= cal_wdata_i;
        end
        cal_rdata_o <= cal_rd_i ? mem[cal_addr_i] : ~cal_rdata_o;
    end
endmodule // sfrsr_mc_model
`default_nettype wire

// >>> bench/sfrsr_ctrl_props.sv
// Port checker for the save/restore sequencer
`timescale 1ns/10ps
`default_nettype none
module sfrsr_ctrl_props #(
    parameter int CAL_AW = 9
) (
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    input wire logic UI_RST_I,
    input wire logic SLEEP_REQ_O,
    input wire logic SLEEP_GRANT_I,
    input wire logic BYPASS_BRINGUP_O,
    input wire logic USE_SAVED_O,
    input wire logic SAVED_LOADED_O,
    input wire logic TRAINING_DONE_I,
    input wire logic TRAFFIC_EN_O,
    input wire logic [CAL_AW-1:0] CAL_ADDR_O,
    input wire logic CAL_RD_O,
    input wire logic CAL_WR_O
);
    logic [6:0] win_cnt;

    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);

    // ==========================================================
    // Cycles since controller reset release, saturating
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) win_cnt <= 7'h00;
        else if (UI_RST_I) win_cnt <= 7'h00;
        else if (win_cnt != 7'h7f) win_cnt <= win_cnt + 7'h01;
    end

    traffic_gated_a: assert property (TRAFFIC_EN_O |-> !SLEEP_REQ_O &&
        !USE_SAVED_O && !SAVED_LOADED_O) else $error("traffic during sequence");
    req_release_a: assert property (SLEEP_REQ_O && SLEEP_GRANT_I |->
        ##[1:2] !SLEEP_REQ_O) else $error("request outlives grant");
    copy_after_a: assert property (CAL_RD_O |-> !SLEEP_REQ_O &&
        !TRAFFIC_EN_O) else $error("copy before grant");
    arm_window_a: assert property ($rose(USE_SAVED_O) |->
        win_cnt <= 7'h32) else $error("restore strobes late");
    strobe_hold_a: assert property (USE_SAVED_O && !TRAINING_DONE_I &&
        !UI_RST_I |=> USE_SAVED_O) else $error("strobe dropped early");
    strobe_drop_a: assert property (SAVED_LOADED_O && TRAINING_DONE_I |->
        ##[1:2] !USE_SAVED_O && !BYPASS_BRINGUP_O) else $error("strobes stuck");
    bypass_pair_a: assert property (BYPASS_BRINGUP_O |->
        USE_SAVED_O) else $error("bypass without saved training");
    loaded_last_a: assert property ($rose(SAVED_LOADED_O) |->
        $past(CAL_WR_O) && $past(CAL_ADDR_O) == {CAL_AW{1'b1}})
        else $error("loaded before last word");
    write_back_a: assert property (CAL_WR_O |-> USE_SAVED_O &&
        !SAVED_LOADED_O) else $error("write back outside restore");
endmodule // sfrsr_ctrl_props
bind sfrsr_ctrl sfrsr_ctrl_props #(.CAL_AW(CAL_AW)) sfrsr_ctrl_props_inst (
    .MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .UI_RST_I(UI_RST_I),
    .SLEEP_REQ_O(SLEEP_REQ_O), .SLEEP_GRANT_I(SLEEP_GRANT_I),
    .BYPASS_BRINGUP_O(BYPASS_BRINGUP_O), .USE_SAVED_O(USE_SAVED_O),
    .SAVED_LOADED_O(SAVED_LOADED_O), .TRAINING_DONE_I(TRAINING_DONE_I),
    .TRAFFIC_EN_O(TRAFFIC_EN_O), .CAL_ADDR_O(CAL_ADDR_O),
    .CAL_RD_O(CAL_RD_O), .CAL_WR_O(CAL_WR_O));
`default_nettype wire

// >>> bench/sfrsr_ctrl_tb.sv
// Self-checking bench for the save/restore sequencer
`timescale 1ns/10ps
`default_nettype none
module sfrsr_ctrl_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ui_rst = 1'b1;
    logic [31:0] seed = 32'h0;
    logic [7:0] lat = 8'h00;
    logic [31:0] rdata, cal_rdata, cal_wdata, seed0;
    logic irq, req, grant, bypass, use_saved, loaded, done, traffic;
    logic cal_rd, cal_wr, rd_seen;
    logic [2:0] cal_addr;
    logic [31:0] rd_q[$];
    logic [31:0] wr_q[$];
    logic exp_byp = 1'b1;
    int error_cnt = 0;
    int comparisons = 0;

    // ==========================================================
    // Clock, design and controller model
    always #2.5 clk = ~clk;

    sfrsr_ctrl #(.CAL_AW(3), .CAL_DW(32)) sfrsr_ctrl_inst (.MCLK_I(clk),
        .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq), .UI_RST_I(ui_rst),
        .SLEEP_REQ_O(req), .SLEEP_GRANT_I(grant), .BYPASS_BRINGUP_O(bypass),
        .USE_SAVED_O(use_saved), .SAVED_LOADED_O(loaded),
        .TRAINING_DONE_I(done), .TRAFFIC_EN_O(traffic),
        .CAL_ADDR_O(cal_addr), .CAL_RD_O(cal_rd), .CAL_RDATA_I(cal_rdata),
        .CAL_WR_O(cal_wr), .CAL_WDATA_O(cal_wdata));

    sfrsr_mc_model sfrsr_mc_model_inst (.clk_i(clk), .rst_n_i(rst_n),
        .ui_rst_i(ui_rst), .sleep_req_i(req), .use_saved_i(use_saved),
        .bypass_i(bypass), .loaded_i(loaded), .cal_rd_i(cal_rd),
        .cal_wr_i(cal_wr), .cal_addr_i(cal_addr), .cal_wdata_i(cal_wdata),
        .seed_i(seed), .lat_i(lat), .grant_o(grant), .done_o(done),
        .cal_rdata_o(cal_rdata));

    // ==========================================================
    // Tasks
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Expected read data is queued for the monitor
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask

    // Bounded wait on traffic (1) or interrupt (0)
    task automatic wait_hi(input bit sel);
        int n;
        n = 0;
        while ((sel ? traffic : irq) !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        #1;
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Monitor: read data the cycle after a read, every written word
    initial rd_seen = 1'b0;
    always @(posedge clk) begin
        rd_seen <= rd;
        if (rd_seen) check("rdata", rdata, rd_q.pop_front());
        if (cal_wr === 1'b1) check("cal_wdata", cal_wdata, wr_q.pop_front());
        if (cal_wr === 1'b1) check("bypass", bypass, 32'(exp_byp));
    end

    // Watchdog sized well above the longest sequence
    initial begin
        #(20000 * 5);
        error_cnt++;
        wrap_up();
    end

    // ==========================================================
    // Main sequence
    initial begin
        seed0 = $urandom(10);
        seed = seed0;
        lat = 8'($urandom_range(63));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        ui_rst <= 1'b0;
        wait_hi(1'b1);
        check("traffic", traffic, 32'h1);
        reg_rd(sfrsr_pkg::REG_CTRL, 32'(sfrsr_pkg::CTRL_RST));
        reg_rd(sfrsr_pkg::REG_STATUS, 32'ha0);
        reg_rd(sfrsr_pkg::REG_CAL_WORDS, 32'h8);
        reg_rd(8'h14, 32'h0);
        reg_wr(sfrsr_pkg::REG_IRQ_MASK, 32'h7);
        reg_rd(sfrsr_pkg::REG_IRQ_MASK, 32'h7);
        $display("test 1 done");
        // Prompt grant, parked entry with arm set
        lat <= 8'h00;
        reg_wr(sfrsr_pkg::REG_CTRL, 32'h7);
        #1;
        check("traffic", traffic, 32'h0);
        wait_hi(1'b0);
        check("irq", irq, 32'h1);
        reg_rd(sfrsr_pkg::REG_IRQ_STAT, 32'h1);
        reg_rd(sfrsr_pkg::REG_STATUS, 32'h74);
        reg_wr(sfrsr_pkg::REG_IRQ_STAT, 32'h1);
        reg_rd(sfrsr_pkg::REG_IRQ_STAT, 32'h0);
        @(posedge clk);
        #1;
        check("irq", irq, 32'h0);
        $display("test 2 done");
        // Reconfiguration: store lost, slow calibration
        for (int i = 0; i < 8; i++) wr_q.push_back(seed0 + 32'(i));
        @(posedge clk);
        seed <= $urandom;
        lat <= 8'($urandom_range(63));
        ui_rst <= 1'b1;
        repeat (4) @(posedge clk);
        ui_rst <= 1'b0;
        wait_hi(1'b1);
        check("use_saved", use_saved, 32'h0);
        check("bypass", bypass, 32'h0);
        check("words left", 32'(wr_q.size()), 32'h0);
        reg_rd(sfrsr_pkg::REG_IRQ_STAT, 32'h2);
        reg_rd(sfrsr_pkg::REG_STATUS, 32'he0);
        $display("test 3 done");
        // Save without self-refresh, event masked then unmasked
        reg_wr(sfrsr_pkg::REG_IRQ_STAT, 32'h7);
        reg_wr(sfrsr_pkg::REG_IRQ_MASK, 32'h0);
        reg_wr(sfrsr_pkg::REG_CTRL, 32'h1);
        #1;
        check("traffic", traffic, 32'h0);
        wait_hi(1'b1);
        check("traffic", traffic, 32'h1);
        reg_rd(sfrsr_pkg::REG_IRQ_STAT, 32'h1);
        #1;
        check("irq", irq, 32'h0);
        reg_wr(sfrsr_pkg::REG_IRQ_MASK, 32'h1);
        @(posedge clk);
        #1;
        check("irq", irq, 32'h1);
        $display("test 4 done");
        // Restore without self-refresh: store reused, bypass stays low
        for (int i = 0; i < 8; i++) wr_q.push_back(seed0 + 32'(i));
        exp_byp = 1'b0;
        reg_wr(sfrsr_pkg::REG_CTRL, 32'h2);
        seed <= $urandom;
        ui_rst <= 1'b1;
        repeat (4) @(posedge clk);
        ui_rst <= 1'b0;
        wait_hi(1'b1);
        check("words left", 32'(wr_q.size()), 32'h0);
        reg_rd(sfrsr_pkg::REG_IRQ_STAT, 32'h3);
        $display("test 5 done");
        // Second power-on reset: store invalid, arm window missed
        repeat (2) @(posedge clk);
        rst_n <= 1'b0;
        ui_rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        reg_wr(sfrsr_pkg::REG_IRQ_MASK, 32'h4);
        reg_wr(sfrsr_pkg::REG_CTRL, 32'h2);
        ui_rst <= 1'b0;
        wait_hi(1'b0);
        check("irq", irq, 32'h1);
        reg_rd(sfrsr_pkg::REG_IRQ_STAT, 32'h4);
        wait_hi(1'b1);
        check("use_saved", use_saved, 32'h0);
        $display("test 6 done");
        wrap_up();
    end
endmodule // sfrsr_ctrl_tb
`default_nettype wire
